/* logic/loop_ctrl_regs.vh */
/*
 * Register offsets, field positions, reset values and window counts for the
 * loop lock-interrupt and low-power controller.
 * Assumes inclusion by bare name from design files under logic/ and from the checker under tb/.
 */
`ifndef LOOP_CTRL_REGS_VH
`define LOOP_CTRL_REGS_VH

// APB byte offsets
`define OFS_LOOP_CONTROL      12'h000
`define OFS_BANDWIDTH_CONTROL 12'h004
`define OFS_BREAK_FLAG        12'h008
`define OFS_STATUS            12'h00c

// Loop control register fields
`define BIT_IRQ_ENABLE        7
`define BIT_IRQ_FLAG          6
`define BIT_POWER_ON          5
`define BIT_BASE_SELECT       4

// Bandwidth control register fields
`define BIT_AUTO_MODE         7
`define BIT_LOCKED            6
`define BIT_TRACKING          5

// Break flag control register fields
`define BIT_BREAK_CLEAR_EN    7

// Status register fields
`define BIT_STAT_OUT_SRC      0
`define BIT_STAT_STOPPED      1

// Reset values
`define RST_IRQ_ENABLE        1'b0
`define RST_POWER_ON          1'b1
`define RST_BASE_SELECT       1'b0
`define RST_AUTO_MODE         1'b0
`define RST_MAN_TRACKING      1'b0
`define RST_BREAK_CLEAR_EN    1'b0

// Reference-cycle windows for tolerance evaluation
`define ACQ_WINDOW_CYCLES     8'd32
`define TRK_WINDOW_CYCLES     8'd64
`define WINDOW_W              8

`endif

/* logic/tolerance_window.v */
/*
 * Tolerance window evaluator: a frequency-error tolerance input must stay
 * good for a whole window of reference ticks before the verdict rises.
 * Assumes refTick and withinTol are synchronous to sys_clk.
 */
`timescale 1ns/1ps
`include "loop_ctrl_regs.vh"

module tolerance_window (
    input  wire                 sys_clk,    // System clock
    input  wire                 srst,       // Synchronous reset
    input  wire                 enable,     // Evaluation active
    input  wire                 refTick,    // One reference clock cycle
    input  wire                 withinTol,  // Error inside tolerance now
    input  wire [`WINDOW_W-1:0] windowLen,  // Window length in ticks
    output reg                  passed      // Whole window was in tolerance
);

    reg [`WINDOW_W-1:0] count_reg;  // Ticks seen in current window
    reg                 good_reg;   // Tolerance held so far this window

    ////////////////////////////////////////////////////////////////////////
    // Verdict changes only at window boundaries or when evaluation is disabled
    always @(posedge sys_clk) begin
        if (srst || !enable) begin
            count_reg <= {`WINDOW_W{1'b0}};
            good_reg  <= 1'b1;
            passed    <= 1'b0;
        end else if (refTick) begin
            if (count_reg == windowLen - 1'b1) begin
                // Boundary: publish verdict, start next window
                passed    <= good_reg && withinTol;
                count_reg <= {`WINDOW_W{1'b0}};
                good_reg  <= 1'b1;
            end else begin
                count_reg <= count_reg + 1'b1;
                good_reg  <= good_reg && withinTol;
            end
        end
    end

endmodule // tolerance_window

/* logic/loop_lock_ctrl.v */
/*
 * Loop lock-change interrupt, wait/stop behaviour, break-state flag
 * protection and automatic acquisition/lock signalling, with APB registers.
 * Assumes crystal/vco tick inputs and tolerance indications come from
 * outside the clock domain; all are synchronised here.
 */
// The APB slave port and the register addresses were left to the implementer.
// Operation
// - Lock change raises request in auto mode
// - Request reaches CPU only when enabled
// - Flag sets regardless of enable bit
// - Manual mode: no interrupt, flag reads zero
// - Vco select allowed while unlocked
// - Wait instruction leaves generator untouched
// - Oscillator enable low holds outputs low
// - Stop with vco selected clears select
// - After stop, crystal drives output, select clear
// - Break clears allowed when clear enable set
// - Clear enable zero protects flag in break
// - Tracking bit set on acquisition tolerance
// - Lock indicator set on lock tolerance
// - Acquisition judged over fixed reference window
// - Lock judged over separate fixed window
// - Control register read clears flag
// - Select refused while power off
`timescale 1ns/1ps
`include "loop_ctrl_regs.vh"

module loop_lock_ctrl (
    input  wire        sys_clk,               // System clock, 100 MHz
    input  wire        srst,                  // Synchronous reset, active high
    // APB slave
    input  wire        psel,                  // Slave select
    input  wire        penable,               // Access phase
    input  wire        pwrite,                // Write direction
    input  wire [11:0] paddr,                 // Byte address
    input  wire [31:0] pwdata,                // Write data
    output reg  [31:0] prdata,                // Read data
    output wire        pready,                // Always ready
    output wire        pslverr,               // Unmapped address
    // System integration unit
    input  wire        oscillator_enable_in,  // Low in stop mode
    input  wire        breakState,            // Processor in break state
    // Clock sources and loop analog status
    input  wire        crystalTick,           // Crystal clock level
    input  wire        vcoTick,               // Vco clock level
    input  wire        refTick,               // Reference divider level
    input  wire        acqTolGood,            // Error within tracking tolerance
    input  wire        lockTolGood,           // Error within lock tolerance
    // Outputs
    output reg         crystal_clock,         // Gated crystal clock
    output reg         generator_output_clock,// Halved selected clock
    output wire        generator_irq_out,     // Interrupt to CPU
    output reg         vco_clock,             // Gated vco clock
    output reg         loopPowered,           // Analog loop power on
    output reg         trackingBandwidth      // Tracking bandwidth to loop
);

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers: first stage feeds only the second stage
    // Reset leaves every stage low; the stop detector needs a high-to-low
    // step, so leaving reset cannot fake a stop entry.
    reg [5:0] sync1_reg;  // First stage
    reg [5:0] sync2_reg;  // Second stage, safe to use
    always @(posedge sys_clk) begin
        if (srst) begin
            sync1_reg <= 6'h00;
            sync2_reg <= 6'h00;
        end else begin
            sync1_reg <= {oscillator_enable_in, crystalTick, vcoTick,
                          refTick, acqTolGood, lockTolGood};
            sync2_reg <= sync1_reg;
        end
    end
    wire oscEnS   = sync2_reg[5];  // Oscillator enable
    wire xtalS    = sync2_reg[4];  // Crystal level
    wire vcoS     = sync2_reg[3];  // Vco level
    wire refS     = sync2_reg[2];  // Reference level
    wire acqTolS  = sync2_reg[1];  // Tracking tolerance
    wire lockTolS = sync2_reg[0];  // Lock tolerance

    // Edge detect on synchronised levels; one-cycle enable pulses
    // Rising edges only; a source stuck high or low gives no pulses
    reg  xtalD_reg;  // Previous crystal level
    reg  vcoD_reg;   // Previous vco level
    reg  refD_reg;   // Previous reference level
    wire xtalRise = xtalS & ~xtalD_reg;
    wire vcoRise  = vcoS & ~vcoD_reg;
    wire refRise  = refS & ~refD_reg;
    always @(posedge sys_clk) begin
        if (srst) begin
            xtalD_reg <= 1'b0;
            vcoD_reg  <= 1'b0;
            refD_reg  <= 1'b0;
        end else begin
            xtalD_reg <= xtalS;
            vcoD_reg  <= vcoS;
            refD_reg  <= refS;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register state
    reg irqEnable_reg;      // loop_irq_enable
    reg irqFlag_reg;        // loop_irq_flag
    reg powerOn_reg;        // loop_power_on
    reg baseSelect_reg;     // base_clock_select
    reg autoMode_reg;       // Automatic bandwidth mode
    reg manTracking_reg;    // Manual tracking value, kept across auto mode
    reg breakClearEn_reg;   // break_clear_enable
    reg locked_reg;         // Phase-settled indicator
    reg tracking_reg;       // tracking_state_bit in auto mode
    reg lockedD_reg;        // Lock indicator one cycle ago

    // Address match against one register offset
    function addrHit;
        input [11:0] addr;  // Bus address
        input [11:0] ofs;   // Register offset
        begin
            addrHit = (addr == ofs);
        end
    endfunction

    // Bus decode
    // One access cycle only: writes and flag clears both land on the
    // edge that ends it.
    wire access   = psel & penable;  // Access phase; pready always high
    wire wrEn     = access & pwrite;
    wire rdEn     = access & ~pwrite;
    wire hitCtrl  = addrHit(paddr, `OFS_LOOP_CONTROL);
    wire hitBw    = addrHit(paddr, `OFS_BANDWIDTH_CONTROL);
    wire hitBrk   = addrHit(paddr, `OFS_BREAK_FLAG);
    wire hitStat  = addrHit(paddr, `OFS_STATUS);
    wire mapped   = hitCtrl | hitBw | hitBrk | hitStat;
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;

    // Stop entry edge
    reg  oscEnD_reg;  // Previous oscillator enable
    wire stopEnter = oscEnD_reg & ~oscEnS;

    ////////////////////////////////////////////////////////////////////////
    // Acquisition and lock evaluation, auto mode only
    // Windows restart whenever evaluation drops, so leaving auto mode
    // or stopping discards any partial verdict.
    wire acqPassed;   // Tracking window verdict
    wire lockPassed;  // Lock window verdict
    wire evalOn = autoMode_reg & powerOn_reg & oscEnS;

    tolerance_window acqWin (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .enable    (evalOn),
        .refTick   (refRise),
        .withinTol (acqTolS),
        .windowLen (`ACQ_WINDOW_CYCLES),
        .passed    (acqPassed)
    );

    tolerance_window lockWin (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .enable    (evalOn & tracking_reg),
        .refTick   (refRise),
        .withinTol (lockTolS),
        .windowLen (`TRK_WINDOW_CYCLES),
        .passed    (lockPassed)
    );

    // Tracking and lock state follow the window verdicts
    // Lock needs tracking first; losing tracking drops lock next cycle
    always @(posedge sys_clk) begin
        if (srst) begin
            tracking_reg <= 1'b0;
            locked_reg   <= 1'b0;
            lockedD_reg  <= 1'b0;
        end else begin
            tracking_reg <= evalOn & acqPassed;
            locked_reg   <= evalOn & tracking_reg & lockPassed;
            lockedD_reg  <= locked_reg;
        end
    end

    // Lock indicator toggled; counted only in auto mode
    wire lockChange = autoMode_reg & (locked_reg ^ lockedD_reg);

    ////////////////////////////////////////////////////////////////////////
    // Flag: set on every lock change in auto mode; cleared by control reads unless
    // the break state protects it. Set wins over clear.
    // A flag raised while stopped still reads back on recovery; the
    // interrupt line itself is gated by the stop level.
    wire ctrlRead  = rdEn & hitCtrl;
    wire clearOk   = ~breakState | breakClearEn_reg;
    always @(posedge sys_clk) begin
        if (srst) begin
            irqFlag_reg <= 1'b0;
        end else if (lockChange) begin
            irqFlag_reg <= 1'b1;
        end else if (ctrlRead && clearOk) begin
            irqFlag_reg <= 1'b0;
        end else if (!autoMode_reg) begin
            irqFlag_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control, bandwidth and break registers
    // Wait mode has no input here at all, so nothing changes on it
    // Stop outranks a write in the same cycle: the select bit must
    // never survive a stop, whatever software asked for.
    always @(posedge sys_clk) begin
        if (srst) begin
            irqEnable_reg    <= `RST_IRQ_ENABLE;
            powerOn_reg      <= `RST_POWER_ON;
            baseSelect_reg   <= `RST_BASE_SELECT;
            autoMode_reg     <= `RST_AUTO_MODE;
            manTracking_reg  <= `RST_MAN_TRACKING;
            breakClearEn_reg <= `RST_BREAK_CLEAR_EN;
            oscEnD_reg       <= 1'b0;
        end else begin
            oscEnD_reg <= oscEnS;
            if (stopEnter || !oscEnS) begin
                baseSelect_reg <= 1'b0;
            end else if (wrEn && hitCtrl) begin
                if (autoMode_reg)
                    irqEnable_reg <= pwdata[`BIT_IRQ_ENABLE];
                // Power cannot drop while the vco drives the output
                powerOn_reg <= pwdata[`BIT_POWER_ON] | baseSelect_reg;
                // No lock interlock, only the power interlock
                baseSelect_reg <= pwdata[`BIT_BASE_SELECT] & powerOn_reg;
            end
            if (wrEn && hitBw) begin
                autoMode_reg <= pwdata[`BIT_AUTO_MODE];
                if (!autoMode_reg)
                    manTracking_reg <= pwdata[`BIT_TRACKING];
            end
            if (wrEn && hitBrk)
                breakClearEn_reg <= pwdata[`BIT_BREAK_CLEAR_EN];
            if (!autoMode_reg && !(wrEn && hitCtrl))
                irqEnable_reg <= 1'b0;  // Enable reads zero in manual mode
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data register, captured during the setup phase
    // Captured at setup so the flag clear on the access edge cannot
    // race the value that software sees.
    always @(posedge sys_clk) begin
        if (srst) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= 32'h00000000;
            if (hitCtrl) begin
                prdata[`BIT_IRQ_ENABLE]  <= irqEnable_reg;
                prdata[`BIT_IRQ_FLAG]    <= irqFlag_reg & autoMode_reg;
                prdata[`BIT_POWER_ON]    <= powerOn_reg;
                prdata[`BIT_BASE_SELECT] <= baseSelect_reg;
                prdata[3:0]              <= 4'hf;
            end else if (hitBw) begin
                prdata[`BIT_AUTO_MODE] <= autoMode_reg;
                prdata[`BIT_LOCKED]    <= locked_reg & autoMode_reg;
                prdata[`BIT_TRACKING]  <= autoMode_reg ? tracking_reg : manTracking_reg;
            end else if (hitBrk) begin
                prdata[`BIT_BREAK_CLEAR_EN] <= breakClearEn_reg;
            end else if (hitStat) begin
                prdata[`BIT_STAT_OUT_SRC] <= baseSelect_reg;
                prdata[`BIT_STAT_STOPPED] <= ~oscEnS;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock outputs: halved selected source, all held low in stop.
    // The source swap here is immediate; no glitch-free stasis is modelled.
    // Sources pass the synchronisers, so the output runs a few cycles
    // behind the pins; only its rate matters to the core.
    always @(posedge sys_clk) begin
        if (srst || !oscEnS) begin
            crystal_clock          <= 1'b0;
            vco_clock              <= 1'b0;
            generator_output_clock <= 1'b0;
            loopPowered            <= 1'b0;
            trackingBandwidth      <= 1'b0;
        end else begin
            crystal_clock     <= xtalS;
            vco_clock         <= vcoS & powerOn_reg;
            loopPowered       <= powerOn_reg;
            trackingBandwidth <= autoMode_reg ? tracking_reg : manTracking_reg;
            if (baseSelect_reg ? vcoRise : xtalRise)
                generator_output_clock <= ~generator_output_clock;
        end
    end

    // Interrupt level while flag and enable both set, gated by stop
    // Manual mode and stop both force the line low regardless of flag
    assign generator_irq_out = irqFlag_reg & irqEnable_reg & autoMode_reg & oscEnS;

endmodule // loop_lock_ctrl

/* tb/loop_lock_ctrl_assertions.sv */
/* Port checker for loop_lock_ctrl.
   Assumes one clock domain, sys_clk, with synchronous srst. */
`timescale 1ns/1ps
`include "loop_ctrl_regs.vh"
module loop_lock_ctrl_checker (
    input wire        sys_clk,
    input wire        srst,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        oscillator_enable_in,
    input wire        breakState,
    input wire        crystal_clock,
    input wire        generator_output_clock,
    input wire        generator_irq_out,
    input wire        vco_clock
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////
    // Access phase reading the control register
    sequence sCtrlRead;
        psel && penable && !pwrite && paddr == `OFS_LOOP_CONTROL;
    endsequence
    // Write that turns automatic bandwidth off
    sequence sAutoOff;
        psel && penable && pwrite && paddr == `OFS_BANDWIDTH_CONTROL && !pwdata[`BIT_AUTO_MODE];
    endsequence
    // Enable low long enough to pass the two-stage synchroniser
    sequence sStopHeld;
        !oscillator_enable_in [*5];
    endsequence
    ////////////////////////////////////////
    AST_STOP_OUTPUTS_LOW: assert property (sStopHeld |-> !crystal_clock && !generator_output_clock
        && !generator_irq_out && !vco_clock) else $error("outputs not held low in stop");
    AST_MANUAL_IRQ_OFF: assert property (sAutoOff |=> !generator_irq_out [*2])
        else $error("interrupt active in manual mode");
    AST_READ_CLEARS_IRQ: assert property (sCtrlRead ##0 !breakState |=> !generator_irq_out)
        else $error("control read left interrupt active");
    AST_DISABLE_IRQ_OFF: assert property (psel && penable && pwrite && paddr == `OFS_LOOP_CONTROL
        && !pwdata[`BIT_IRQ_ENABLE] |=> !generator_irq_out) else $error("interrupt active while disabled");
    AST_CTRL_LOW_BITS: assert property (sCtrlRead |-> prdata[3:0] == 4'hf)
        else $error("unused control bits not read as ones");
    AST_PREADY_HIGH: assert property (psel |-> pready) else $error("pready low");
    AST_UNMAPPED_ERR: assert property (psel && penable && paddr >= 12'h010 |-> pslverr
        && (pwrite || prdata == 32'h0)) else $error("unmapped access not refused");
    AST_MAPPED_OK: assert property (psel && penable && paddr[1:0] == 2'b00 && paddr < 12'h010 |-> !pslverr)
        else $error("mapped access refused");
    AST_PRDATA_HOLDS: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data changed outside read setup");
endmodule // loop_lock_ctrl_checker
bind loop_lock_ctrl loop_lock_ctrl_checker loop_lock_ctrl_checker_inst (
    .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .oscillator_enable_in(oscillator_enable_in), .breakState(breakState),
    .crystal_clock(crystal_clock), .generator_output_clock(generator_output_clock),
    .generator_irq_out(generator_irq_out), .vco_clock(vco_clock));

/* tb/clock_source_model.sv */
/* Crystal, vco and reference sources plus loop tolerance indications.
   Assumes settle is driven by the bench to model the loop converging. */
`timescale 1ns/1ps
module clock_source_model (
    input  wire  sys_clk,
    input  wire  settle,
    output logic crystalTick = 1'b0,
    output logic vcoTick     = 1'b0,
    output logic refTick     = 1'b0,
    output logic acqTolGood  = 1'b0,
    output logic lockTolGood = 1'b0
);
    logic [7:0] cnt = 8'h00; // Shared divider
    // Sources run free: a crystal does not stop between accesses
    always @(posedge sys_clk) begin
        cnt         <= cnt + 8'h01;
        vcoTick     <= cnt[0];
        crystalTick <= cnt[1];
        refTick     <= cnt[2]; // Period of 8 system cycles
        acqTolGood  <= settle;
        lockTolGood <= settle;
    end
endmodule // clock_source_model

/* tb/tb_pll_lock_irq_lowpower_ctrl.sv */
/* Register-level bench for loop_lock_ctrl.
   Assumes a 100 MHz sys_clk and a reference tick of 8 system cycles. */
`timescale 1ns/1ps
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_fail++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_pll_lock_irq_lowpower_ctrl;
    logic        sys_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr  = 12'h000;
    logic [31:0] pwdata = 32'h0, rd;
    logic        oscillator_enable_in = 1'b1, breakState = 1'b0, settle = 1'b0;
    wire  [31:0] prdata;
    wire         pready, pslverr, crystalTick, vcoTick, refTick, acqTolGood, lockTolGood;
    wire         crystal_clock, generator_output_clock, generator_irq_out, vco_clock;
    wire         loopPowered, trackingBandwidth;
    int          n_fail = 0, samples_checked = 0, cyc = 0, t0, t1, t2, nt;
    loop_lock_ctrl loop_lock_ctrl_inst (.sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .oscillator_enable_in(oscillator_enable_in), .breakState(breakState), .crystalTick(crystalTick),
        .vcoTick(vcoTick), .refTick(refTick), .acqTolGood(acqTolGood), .lockTolGood(lockTolGood),
        .crystal_clock(crystal_clock), .generator_output_clock(generator_output_clock),
        .generator_irq_out(generator_irq_out), .vco_clock(vco_clock), .loopPowered(loopPowered),
        .trackingBandwidth(trackingBandwidth));
    clock_source_model clock_source_model_inst (.sys_clk(sys_clk), .settle(settle), .crystalTick(crystalTick),
        .vcoTick(vcoTick), .refTick(refTick), .acqTolGood(acqTolGood), .lockTolGood(lockTolGood));
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) cyc <= cyc + 1;
    ////////////////////////////////////////
    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        `CHECK(pslverr, (a >= 12'h010))
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        `CHECK(rd, exp)
    endtask
    // Poll one bit until it reads v, bounded
    task automatic poll(input logic [11:0] a, input int b, input logic v, output int t);
        int n;
        n = 0;
        do begin
            apb(1'b0, a, 32'h0);
            n++;
        end while (rd[b] !== v && n < 600);
        if (rd[b] !== v) n_fail++;
        t = cyc;
    endtask
    // Toggles of the output clock over 64 system cycles, sampled settled
    task automatic count_toggles(output int nx);
        logic last;
        nx = 0;
        @(posedge sys_clk);
        #1 last = generator_output_clock;
        repeat (64) begin
            @(posedge sys_clk);
            #1 if (generator_output_clock !== last) nx++;
            last = generator_output_clock;
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    ////////////////////////////////////////
    // Watchdog: whole sequence needs well under 20k cycles
    initial begin
        #200000;
        n_fail++;
        give_verdict();
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        rd_chk(12'h000, 32'h2f);
        rd_chk(12'h004, 32'h00);
        rd_chk(12'h008, 32'h00);
        rd_chk(12'h010, 32'h00); // Unmapped: refused, reads zero
        apb(1'b1, 12'h000, 32'h00);
        apb(1'b1, 12'h000, 32'h10);
        rd_chk(12'h000, 32'h0f);
        `CHECK(loopPowered, 1'b0)
        apb(1'b1, 12'h000, 32'h20);
        apb(1'b1, 12'h000, 32'h30);
        rd_chk(12'h000, 32'h3f);
        count_toggles(nt);
        `CHECK(nt, 32)
        apb(1'b1, 12'h000, 32'h20);
        count_toggles(nt);
        `CHECK(nt, 16)
        apb(1'b1, 12'h000, 32'ha0);
        rd_chk(12'h000, 32'h2f);
        apb(1'b1, 12'h004, 32'h80);
        t0 = cyc;
        settle <= 1'b1;
        poll(12'h004, 5, 1'b1, t1);
        `CHECK((t1 - t0) >= 248, 1'b1)
        `CHECK((t1 - t0) <= 768, 1'b1)
        `CHECK(trackingBandwidth, 1'b1)
        `CHECK(rd[6], 1'b0)
        poll(12'h004, 6, 1'b1, t2);
        `CHECK((t2 - t1) >= 496, 1'b1)
        `CHECK((t2 - t1) <= 1536, 1'b1)
        `CHECK(generator_irq_out, 1'b0)
        apb(1'b1, 12'h000, 32'ha0);
        breakState <= 1'b1;
        #1 `CHECK(generator_irq_out, 1'b1)
        rd_chk(12'h000, 32'hef);
        rd_chk(12'h000, 32'hef);
        breakState <= 1'b0;
        rd_chk(12'h000, 32'hef);
        rd_chk(12'h000, 32'haf);
        settle <= 1'b0;
        poll(12'h004, 6, 1'b0, t2);
        #1 `CHECK(generator_irq_out, 1'b1)
        apb(1'b1, 12'h008, 32'h80);
        breakState <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        breakState <= 1'b0;
        rd_chk(12'h000, 32'haf);
        settle <= 1'b1;
        poll(12'h004, 6, 1'b1, t2);
        apb(1'b1, 12'h000, 32'hb0);
        count_toggles(nt);
        `CHECK(nt, 32)
        apb(1'b1, 12'h004, 32'h00);
        #1 `CHECK(generator_irq_out, 1'b0)
        rd_chk(12'h000, 32'h3f);
        apb(1'b1, 12'h000, 32'hb0);
        oscillator_enable_in <= 1'b0;
        repeat (6) @(posedge sys_clk);
        repeat (8) begin
            @(posedge sys_clk);
            #1 `CHECK({crystal_clock, generator_output_clock, generator_irq_out, vco_clock}, 4'h0)
        end
        rd_chk(12'h00c, 32'h02);
        oscillator_enable_in <= 1'b1;
        repeat (6) @(posedge sys_clk);
        rd_chk(12'h000, 32'h2f);
        rd_chk(12'h00c, 32'h00);
        count_toggles(nt);
        `CHECK(nt, 16)
        apb(1'b1, 12'h000, 32'h00);
        rd_chk(12'h000, 32'h0f);
        `CHECK(loopPowered, 1'b0)
        apb(1'b1, 12'h000, 32'h20);
        repeat (1024) @(posedge sys_clk);
        apb(1'b1, 12'h000, 32'h30);
        rd_chk(12'h000, 32'h3f);
        give_verdict();
    end
endmodule // tb_pll_lock_irq_lowpower_ctrl
